// ---- src/uart_irq_map.svh ----
// Register offsets, field positions, interrupt codes and trigger values
`ifndef UART_IRQ_MAP_SVH
`define UART_IRQ_MAP_SVH

`define OFS_ISS 12'h000
`define OFS_FSC 12'h004
`define OFS_IEN 12'h008
`define OFS_EFE 12'h00C
`define OFS_TTS 12'h010
`define OFS_LST 12'h014
`define OFS_MST 12'h018
`define OFS_RXH 12'h01C
`define OFS_TXH 12'h020

`define FSC_EN 0
`define FSC_RXRST 1
`define FSC_TXRST 2
`define FSC_DMA 3
`define EFE_ENH 4
`define EFE_ARTS 6
`define EFE_ACTS 7
`define TTS_RS485 3
`define IEN_RX 0
`define IEN_TX 1
`define IEN_LINE 2
`define IEN_MODEM 3
`define IEN_XOFF 5
`define IEN_RTS 6
`define IEN_CTS 7

`define REG8_RST 8'h00
`define WORD_ZERO 32'h0000_0000

`define CODE_LINE 6'h06
`define CODE_RXTO 6'h0C
`define CODE_RECEIVE_READY_PIN 6'h04
`define CODE_TRANSMIT_READY_PIN 6'h02
`define CODE_MODEM 6'h00
`define CODE_XOFF 6'h10
`define CODE_FLOW 6'h20
`define CODE_NONE 6'h01

`define TMO_CHARS 8'h04
`define TMO_EXTRA_BITS 8'h0C

`define TRG_1 8'h01
`define TRG_4 8'h04
`define TRG_8 8'h08
`define TRG_14 8'h0E
`define TRG_16 8'h10
`define TRG_24 8'h18
`define TRG_28 8'h1C
`define TRG_30 8'h1E

`endif

// ---- src/uart_irq_pkg.sv ----
// Types shared by the interrupt and FIFO control logic
package uart_irq_pkg;
   typedef logic [7:0] reg8_t;
   typedef logic [5:0] isr_code_t;
   typedef enum logic [1:0] {TBL_A, TBL_B, TBL_C, TBL_D} trig_table_t;
endpackage : uart_irq_pkg

// ---- src/irq_priority_pick.sv ----
// Ranks pending interrupt sources and yields the status code
`timescale 1ns/1ps
`include "uart_irq_map.svh"
module irq_priority_pick
   import uart_irq_pkg::*;
(
   input wire logic [6:0] pend, // Index 0 is level 1
   output isr_code_t code // Highest pending code
);
   always_comb begin
      if (pend[0]) code = `CODE_LINE;
      else if (pend[1]) code = `CODE_RXTO;
      else if (pend[2]) code = `CODE_RECEIVE_READY_PIN;
      else if (pend[3]) code = `CODE_TRANSMIT_READY_PIN;
      else if (pend[4]) code = `CODE_MODEM;
      else if (pend[5]) code = `CODE_XOFF;
      else if (pend[6]) code = `CODE_FLOW;
      else code = `CODE_NONE;
   end
endmodule : irq_priority_pick

// ---- src/uart_irq_fifo_ctrl.sv ----
// Prioritized interrupt status and FIFO control for one serial channel
`timescale 1ns/1ps
`include "uart_irq_map.svh"
module uart_irq_fifo_ctrl
   import uart_irq_pkg::*;
#(
   parameter logic [7:0] FIFO_DEPTH = 8'h80
)
(
   input wire logic CLK_SYS, // System clock
   input wire logic RSTN, // Synchronous reset, active low
   input wire logic PSEL, // APB select
   input wire logic PENABLE, // APB enable
   input wire logic PWRITE, // APB direction
   input wire logic [11:0] PADDR, // APB byte address
   input wire logic [31:0] PWDATA, // APB write data
   output logic [31:0] PRDATA, // APB read data
   output logic PREADY, // APB ready
   output logic PSLVERR, // APB error on unmapped address
   input wire logic [7:0] RX_LEVEL, // Receive FIFO count
   input wire logic [7:0] TX_LEVEL, // Transmit FIFO count
   input wire logic [7:0] RX_DATA, // Receive FIFO head
   input wire logic RX_CHAR, // Character entered receive FIFO
   input wire logic BIT_TICK, // One pulse per bit time
   input wire logic [3:0] CHAR_BITS, // Bits per character frame
   input wire logic [3:0] LINE_ERR, // Line error events, status bits 4:1
   input wire logic [3:0] MODEM_DELTA, // Modem change events
   input wire logic [3:0] MODEM_LINES, // Modem input levels
   input wire logic XOFF_MATCH, // Xoff character received
   input wire logic XON_MATCH, // Xon character received
   input wire logic SPECIAL_MATCH, // Special character received
   input wire logic CTS_IN, // Clear-to-send level, high inactive
   input wire logic RTS_OUT, // Request-to-send level, high inactive
   input wire logic TX_EMPTY, // Transmitter fully empty
   output logic IRQ, // Interrupt request
   output logic FIFO_EN, // FIFOs enabled
   output logic DMA_MODE, // Ready pin mode
   output logic RX_FIFO_RST, // Receive FIFO reset pulse
   output logic TX_FIFO_RST, // Transmit FIFO reset pulse
   output logic RX_POP, // Receive holding read pulse
   output logic TX_PUSH, // Transmit holding write pulse
   output logic [7:0] TX_DATA, // Transmit holding data
   output logic [7:0] RX_TRIG, // Active receive trigger
   output logic [7:0] TX_TRIG, // Active transmit trigger
   output logic RECEIVE_READY_PIN_N, // Receive ready, active low
   output logic TRANSMIT_READY_PIN_N // Transmit ready, active low
);

   function automatic reg8_t rx_trig_f(input trig_table_t t, input logic [1:0] s);
      if (t == TBL_B) begin
         unique case (s)
            2'b00: return `TRG_8;
            2'b01: return `TRG_16;
            2'b10: return `TRG_24;
            2'b11: return `TRG_28;
         endcase
      end
      unique case (s)
         2'b00: return `TRG_1;
         2'b01: return `TRG_4;
         2'b10: return `TRG_8;
         2'b11: return `TRG_14;
      endcase
   endfunction : rx_trig_f

   function automatic reg8_t tx_trig_f(input trig_table_t t, input logic [1:0] s);
      if (t == TBL_B) begin
         unique case (s)
            2'b00: return `TRG_16;
            2'b01: return `TRG_8;
            2'b10: return `TRG_24;
            2'b11: return `TRG_30;
         endcase
      end
      return `TRG_1;
   endfunction : tx_trig_f

   // Register state
   reg8_t ien_ff, efe_ff, tts_ff;
   logic [1:0] rx_sel_ff, tx_sel_ff;
   logic [3:0] lst_ff, mst_ff;
   logic tmo_ff, tx_ff, xoff_ff, spec_ff, flow_ff;
   logic [7:0] tmo_cnt_ff;
   logic below_q_ff, empty_q_ff, over_ff, txe_q_ff, cts_q_ff, rts_q_ff;

   // APB decode
   wire acc = PSEL & PENABLE & PREADY;
   wire wr_acc = acc & PWRITE;
   wire rd_acc = acc & ~PWRITE;
   wire nxt_pready = PSEL & PENABLE & ~PREADY;
   wire hit_iss = PADDR == `OFS_ISS;
   wire hit_fsc = PADDR == `OFS_FSC;
   wire hit_ien = PADDR == `OFS_IEN;
   wire hit_efe = PADDR == `OFS_EFE;
   wire hit_tts = PADDR == `OFS_TTS;
   wire hit_lst = PADDR == `OFS_LST;
   wire hit_mst = PADDR == `OFS_MST;
   wire hit_rxh = PADDR == `OFS_RXH;
   wire hit_txh = PADDR == `OFS_TXH;
   wire mapped = hit_iss | hit_fsc | hit_ien | hit_efe | hit_tts | hit_lst | hit_mst
      | hit_rxh | hit_txh;
   wire rd_iss = rd_acc & hit_iss;
   wire rd_lst = rd_acc & hit_lst;
   wire rd_mst = rd_acc & hit_mst;
   wire rd_rxh = rd_acc & hit_rxh;
   wire wr_fsc = wr_acc & hit_fsc;
   wire wr_txh = wr_acc & hit_txh;
   wire enh = efe_ff[`EFE_ENH];

   // Trigger selection, one table for both directions
   wire trig_table_t table_sel = trig_table_t'(tts_ff[5:4]);
   wire reg8_t rx_trig = FIFO_EN ? rx_trig_f(table_sel, rx_sel_ff) : `TRG_1;
   wire reg8_t tx_trig = FIFO_EN ? tx_trig_f(table_sel, tx_sel_ff) : `TRG_1;

   // Source conditions
   wire rx_at_trig = RX_LEVEL >= rx_trig;
   wire below = TX_LEVEL < tx_trig;
   wire empty = TX_LEVEL == 8'h00;
   wire tx_ev = (below & ~below_q_ff & over_ff) | (empty & ~empty_q_ff & ~over_ff)
      | (tts_ff[`TTS_RS485] & TX_EMPTY & ~txe_q_ff);
   wire [7:0] tmo_limit = 8'((`TMO_CHARS * {4'h0, CHAR_BITS}) + `TMO_EXTRA_BITS);
   wire tmo_hit = FIFO_EN & BIT_TICK & (RX_LEVEL != 8'h00) & (8'(tmo_cnt_ff + 8'h01) == tmo_limit);
   wire tmo_rst = RX_CHAR | rd_rxh | (RX_LEVEL == 8'h00);
   wire cts_rise = CTS_IN & ~cts_q_ff & efe_ff[`EFE_ACTS] & ien_ff[`IEN_CTS];
   wire rts_rise = RTS_OUT & ~rts_q_ff & efe_ff[`EFE_ARTS] & ien_ff[`IEN_RTS];

   // Pending vector, index 0 is priority level 1
   wire [6:0] pend = {
      flow_ff & enh,
      (xoff_ff | spec_ff) & ien_ff[`IEN_XOFF] & enh,
      (|mst_ff) & ien_ff[`IEN_MODEM],
      tx_ff & ien_ff[`IEN_TX],
      rx_at_trig & ien_ff[`IEN_RX],
      tmo_ff & ien_ff[`IEN_RX],
      (|lst_ff) & ien_ff[`IEN_LINE]
   };
   wire any_pend = |pend;
   isr_code_t isr_code;

   irq_priority_pick u_pick (
      .pend (pend),
      .code (isr_code)
   );

   // Read data selection
   wire [7:0] iss_rd = {FIFO_EN, FIFO_EN, isr_code};
   wire [7:0] rd_mux = hit_iss ? iss_rd :
      hit_ien ? ien_ff :
      hit_efe ? efe_ff :
      hit_tts ? tts_ff :
      hit_lst ? {3'b000, lst_ff, RX_LEVEL != 8'h00} :
      hit_mst ? {MODEM_LINES, mst_ff} :
      hit_rxh ? RX_DATA : `REG8_RST;

   // Bus answer, one wait state
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= `WORD_ZERO;
      end else begin
         PREADY <= nxt_pready;
         PSLVERR <= nxt_pready & ~mapped;
         PRDATA <= (nxt_pready & ~PWRITE) ? {24'h00_0000, rd_mux} : `WORD_ZERO;
      end
   end

   // Software control registers
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         ien_ff <= `REG8_RST;
         efe_ff <= `REG8_RST;
         tts_ff <= `REG8_RST;
      end else begin
         if (wr_acc & hit_ien) ien_ff <= PWDATA[7:0];
         if (wr_acc & hit_efe) efe_ff <= PWDATA[7:0];
         if (wr_acc & hit_tts) tts_ff <= PWDATA[7:0];
      end
   end

   // FIFO setup control writes
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         FIFO_EN <= 1'b0;
         DMA_MODE <= 1'b0;
         rx_sel_ff <= 2'b00;
         tx_sel_ff <= 2'b00;
         RX_FIFO_RST <= 1'b0;
         TX_FIFO_RST <= 1'b0;
      end else begin
         RX_FIFO_RST <= wr_fsc & PWDATA[`FSC_EN] & PWDATA[`FSC_RXRST];
         TX_FIFO_RST <= wr_fsc & PWDATA[`FSC_EN] & PWDATA[`FSC_TXRST];
         if (wr_fsc) begin
            FIFO_EN <= PWDATA[`FSC_EN];
            if (PWDATA[`FSC_EN]) begin
               DMA_MODE <= PWDATA[`FSC_DMA];
               rx_sel_ff <= PWDATA[7:6];
               if (enh) tx_sel_ff <= PWDATA[5:4];
            end
         end
      end
   end

   // Holding register strobes
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         RX_POP <= 1'b0;
         TX_PUSH <= 1'b0;
         TX_DATA <= `REG8_RST;
      end else begin
         RX_POP <= rd_rxh;
         TX_PUSH <= wr_txh;
         if (wr_txh) TX_DATA <= PWDATA[7:0];
      end
   end

   // Edge history and transmit reload tracking
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         below_q_ff <= 1'b0;
         empty_q_ff <= 1'b1;
         over_ff <= 1'b0;
         txe_q_ff <= 1'b1;
         cts_q_ff <= 1'b1;
         rts_q_ff <= 1'b1;
      end else begin
         below_q_ff <= below;
         empty_q_ff <= empty;
         txe_q_ff <= TX_EMPTY;
         cts_q_ff <= CTS_IN;
         rts_q_ff <= RTS_OUT;
         if (TX_LEVEL > tx_trig) over_ff <= 1'b1;
         else if (below) over_ff <= 1'b0;
      end
   end

   // Receive timeout timer
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) tmo_cnt_ff <= 8'h00;
      else if (tmo_rst | tmo_hit) tmo_cnt_ff <= 8'h00;
      else if (BIT_TICK & ~tmo_ff & FIFO_EN) tmo_cnt_ff <= 8'(tmo_cnt_ff + 8'h01);
   end

   // Sticky sources, set wins over clear
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         lst_ff <= 4'h0;
         mst_ff <= 4'h0;
         tmo_ff <= 1'b0;
         tx_ff <= 1'b0;
         xoff_ff <= 1'b0;
         spec_ff <= 1'b0;
         flow_ff <= 1'b0;
      end else begin
         lst_ff <= LINE_ERR | (lst_ff & {4{~rd_lst}});
         mst_ff <= MODEM_DELTA | (mst_ff & {4{~rd_mst}});
         tmo_ff <= tmo_hit | (tmo_ff & ~rd_rxh);
         tx_ff <= tx_ev | (tx_ff & ~(rd_iss | wr_txh));
         xoff_ff <= XOFF_MATCH | (xoff_ff & ~(rd_iss | XON_MATCH));
         spec_ff <= SPECIAL_MATCH | (spec_ff & ~(rd_iss | RX_CHAR));
         flow_ff <= cts_rise | rts_rise | (flow_ff & ~rd_mst);
      end
   end

   // Interrupt, trigger and ready pin outputs
   wire rx_rdy = DMA_MODE ? (rx_at_trig | tmo_ff) : (RX_LEVEL != 8'h00);
   wire tx_rdy = DMA_MODE ? (TX_LEVEL < FIFO_DEPTH) : empty;
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         IRQ <= 1'b0;
         RX_TRIG <= `TRG_1;
         TX_TRIG <= `TRG_1;
         RECEIVE_READY_PIN_N <= 1'b1;
         TRANSMIT_READY_PIN_N <= 1'b1;
      end else begin
         IRQ <= any_pend;
         RX_TRIG <= rx_trig;
         TX_TRIG <= tx_trig;
         RECEIVE_READY_PIN_N <= ~rx_rdy;
         TRANSMIT_READY_PIN_N <= ~tx_rdy;
      end
   end

   // Checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RSTN);

   idle_code_a: assert property (!any_pend |-> isr_code == `CODE_NONE)
      else $error("idle status code wrong");
   line_first_a: assert property (pend[0] |-> isr_code == `CODE_LINE)
      else $error("line source not ranked first");
   irq_follow_a: assert property (any_pend |=> IRQ)
      else $error("irq missing while pending");
   irq_drop_a: assert property (!any_pend |=> !IRQ)
      else $error("irq stuck without pending source");
   fifo_bits_a: assert property (iss_rd[7:6] == {2{FIFO_EN}})
      else $error("fifo status bits wrong");
   rx_rst_pulse_a: assert property (RX_FIFO_RST |=> !RX_FIFO_RST)
      else $error("receive reset not a single pulse");
   fcr_gate_a: assert property (wr_fsc && !PWDATA[0] |=> !FIFO_EN && $stable(DMA_MODE))
      else $error("control bits applied without enable");
   tx_sel_lock_a: assert property (wr_fsc && !enh |=> $stable(tx_sel_ff))
      else $error("transmit trigger written without enhanced enable");
   flow_mask_a: assert property (!enh |-> !pend[6] && !pend[5])
      else $error("enhanced sources reported while disabled");
   line_set_a: assert property (LINE_ERR != 4'h0 |=> lst_ff != 4'h0 ##0 (|lst_ff))
      else $error("line error not captured");
   tmo_clear_a: assert property (rd_rxh |=> !tmo_ff)
      else $error("timeout survived receive read");
   tx_clear_a: assert property (wr_txh && !tx_ev |=> !tx_ff)
      else $error("transmit ready survived holding write");
   xoff_hold_a: assert property (xoff_ff && !XON_MATCH && !rd_iss |=> xoff_ff)
      else $error("xoff flag dropped early");

endmodule : uart_irq_fifo_ctrl

// ---- tb/fifo_side_model.sv ----
// Behavioural FIFO counters standing in for the serial data path
`timescale 1ns/1ps
module fifo_side_model (
   input wire logic clk, // System clock
   input wire logic rstn, // Synchronous reset, active low
   input wire logic add_rx, // Character arrives
   input wire logic drain_tx, // Character leaves transmitter
   input wire logic rx_pop, // Host read of receive holding
   input wire logic tx_push, // Host write of transmit holding
   input wire logic rx_rst, // Receive FIFO reset
   input wire logic tx_rst, // Transmit FIFO reset
   output logic [7:0] rx_level, // Receive count
   output logic [7:0] tx_level, // Transmit count
   output logic [7:0] rx_data // Head byte
);
   // Head byte tracks the count so each read sees a new value
   assign rx_data = 8'hA0 + rx_level;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rx_level <= 8'h00;
         tx_level <= 8'h00;
      end else begin
         rx_level <= rx_rst ? 8'h00 : rx_level + {7'h00, add_rx} - {7'h00, rx_pop};
         tx_level <= tx_rst ? 8'h00 : tx_level + {7'h00, tx_push} - {7'h00, drain_tx};
      end
   end
endmodule : fifo_side_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the interrupt status and FIFO control block
`timescale 1ns/1ps
`include "uart_irq_map.svh"
module tb_top;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [11:0] pa = 12'h000;
   logic [31:0] pd = 32'h0000_0000;
   logic bit_tick = 1'b0;
   logic cts = 1'b0;
   logic rts = 1'b0;
   logic txe = 1'b0;
   logic [6:0] ev = 7'h00;
   logic [31:0] prd, q;
   logic prdy, perr, qerr, irq, fifo_en, dma, rx_rst, tx_rst, rx_pop, tx_push, rrp_n, trp_n;
   logic [7:0] rx_level, tx_level, rx_data, tx_data, rx_trig, tx_trig;
   int errors = 0;
   int checks_done = 0;
   // Columns: enhanced, table, fifo control, rx trigger, tx trigger, enabled
   logic [7:0] tbl [12][6] = '{
      '{8'h10, 8'h00, 8'h01, 8'h01, 8'h01, 8'h01},
      '{8'h10, 8'h00, 8'h41, 8'h04, 8'h01, 8'h01},
      '{8'h10, 8'h00, 8'h81, 8'h08, 8'h01, 8'h01},
      '{8'h10, 8'h00, 8'hC1, 8'h0E, 8'h01, 8'h01},
      '{8'h10, 8'h10, 8'h01, 8'h08, 8'h10, 8'h01},
      '{8'h10, 8'h10, 8'h51, 8'h10, 8'h08, 8'h01},
      '{8'h10, 8'h10, 8'hA1, 8'h18, 8'h18, 8'h01},
      '{8'h10, 8'h10, 8'hF1, 8'h1C, 8'h1E, 8'h01},
      '{8'h10, 8'h10, 8'h01, 8'h08, 8'h10, 8'h01},
      '{8'h00, 8'h10, 8'hF1, 8'h1C, 8'h10, 8'h01},
      '{8'h00, 8'h00, 8'hC0, 8'h01, 8'h01, 8'h00},
      '{8'h10, 8'h00, 8'h41, 8'h04, 8'h01, 8'h01}};

   always #20 clk = ~clk;

   uart_irq_fifo_ctrl u_dut (
      .CLK_SYS(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
      .PWDATA(pd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .RX_LEVEL(rx_level),
      .TX_LEVEL(tx_level), .RX_DATA(rx_data), .RX_CHAR(ev[0]), .BIT_TICK(bit_tick),
      .CHAR_BITS(4'hA), .LINE_ERR({2'b00, ev[5], 1'b0}), .MODEM_DELTA({3'b000, ev[6]}),
      .MODEM_LINES(4'h0), .XOFF_MATCH(ev[1]), .XON_MATCH(ev[2]), .SPECIAL_MATCH(ev[3]),
      .CTS_IN(cts), .RTS_OUT(rts), .TX_EMPTY(txe), .IRQ(irq), .FIFO_EN(fifo_en),
      .DMA_MODE(dma), .RX_FIFO_RST(rx_rst), .TX_FIFO_RST(tx_rst), .RX_POP(rx_pop),
      .TX_PUSH(tx_push), .TX_DATA(tx_data), .RX_TRIG(rx_trig), .TX_TRIG(tx_trig),
      .RECEIVE_READY_PIN_N(rrp_n), .TRANSMIT_READY_PIN_N(trp_n));

   fifo_side_model u_far (
      .clk(clk), .rstn(rstn), .add_rx(ev[0]), .drain_tx(ev[4]), .rx_pop(rx_pop),
      .tx_push(tx_push), .rx_rst(rx_rst), .tx_rst(tx_rst), .rx_level(rx_level),
      .tx_level(tx_level), .rx_data(rx_data));

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask : cyc

   task automatic done(input string nm);
      $display("test %s finished", nm);
   endtask : done

   // Setup, access, then hold until ready is seen at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      pa <= a;
      pd <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (prdy !== 1'b1 && n < 20);
      if (prdy !== 1'b1) begin
         errors++;
         complete_run();
      end else begin
         q = prd;
         qerr = perr;
         psel <= 1'b0;
         pen <= 1'b0;
      end
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk("prdata", {24'h0, e}, q);
   endtask : rd

   task automatic ev_pulse(input logic [6:0] m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 7'h00;
   endtask : ev_pulse

   initial begin
      cyc(10);
      rstn <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         wr(`OFS_EFE, tbl[i][0]);
         wr(`OFS_TTS, tbl[i][1]);
         wr(`OFS_FSC, tbl[i][2]);
         cyc(2);
         chk("rx_trig", {24'h0, tbl[i][3]}, {24'h0, rx_trig});
         chk("tx_trig", {24'h0, tbl[i][4]}, {24'h0, tx_trig});
         chk("fifo_en", {24'h0, tbl[i][5]}, {31'h0, fifo_en});
         rd(`OFS_ISS, {tbl[i][5][0], tbl[i][5][0], 6'h01});
      end
      done("tables");
      rstn <= 1'b0;
      cyc(2);
      chk("rst_outs", 32'h0, {16'h0, irq, fifo_en, dma, rx_rst, tx_rst, rx_pop, tx_push, 1'b0, tx_data});
      chk("rst_trig", 32'h0101, {16'h0, rx_trig, tx_trig});
      chk("rst_pins", 32'h3, {30'h0, rrp_n, trp_n});
      rstn <= 1'b1;
      rd(`OFS_ISS, 8'h01);
      rd(`OFS_FSC, 8'h00);
      wr(`OFS_EFE, 8'h10);
      wr(`OFS_FSC, 8'h41);
      done("reset");
      wr(`OFS_IEN, 8'h0D);
      repeat (4) ev_pulse(7'h01);
      ev_pulse(7'h60);
      cyc(2);
      chk("irq", 32'h1, {31'h0, irq});
      chk("rx_pin_n", 32'h0, {31'h0, rrp_n});
      rd(`OFS_ISS, 8'hC6);
      rd(`OFS_LST, 8'h05);
      rd(`OFS_ISS, 8'hC4);
      rd(`OFS_RXH, 8'hA4);
      rd(`OFS_ISS, 8'hC0);
      rd(`OFS_MST, 8'h01);
      rd(`OFS_ISS, 8'hC1);
      chk("irq", 32'h0, {31'h0, irq});
      done("priority");
      bit_tick <= 1'b1;
      rd(`OFS_RXH, 8'hA3);
      cyc(36);
      rd(`OFS_ISS, 8'hC1);
      cyc(20);
      rd(`OFS_ISS, 8'hCC);
      rd(`OFS_RXH, 8'hA2);
      rd(`OFS_ISS, 8'hC1);
      bit_tick <= 1'b0;
      done("timeout");
      wr(`OFS_IEN, 8'h02);
      wr(`OFS_TXH, 8'h3C);
      cyc(1);
      chk("tx_data", 32'h3C, {24'h0, tx_data});
      wr(`OFS_TXH, 8'h3D);
      apb(1'b0, `OFS_ISS, 32'h0000_0000);
      rd(`OFS_ISS, 8'hC1);
      repeat (2) ev_pulse(7'h10);
      cyc(2);
      rd(`OFS_ISS, 8'hC2);
      rd(`OFS_ISS, 8'hC1);
      wr(`OFS_TXH, 8'h3E);
      ev_pulse(7'h10);
      cyc(3);
      chk("irq", 32'h1, {31'h0, irq});
      wr(`OFS_TXH, 8'h3F);
      rd(`OFS_ISS, 8'hC1);
      wr(`OFS_FSC, 8'h04);
      cyc(2);
      chk("tx_level", 32'h1, {24'h0, tx_level});
      wr(`OFS_FSC, 8'h4F);
      cyc(2);
      chk("levels", 32'h0, {16'h0, rx_level, tx_level});
      chk("dma", 32'h1, {31'h0, dma});
      chk("dma_pins", 32'h2, {30'h0, rrp_n, trp_n});
      done("transmit");
      wr(`OFS_IEN, 8'hA0);
      ev_pulse(7'h02);
      rd(`OFS_ISS, 8'hD0);
      rd(`OFS_ISS, 8'hC1);
      ev_pulse(7'h02);
      ev_pulse(7'h04);
      rd(`OFS_ISS, 8'hC1);
      ev_pulse(7'h08);
      cyc(2);
      chk("irq", 32'h1, {31'h0, irq});
      ev_pulse(7'h01);
      rd(`OFS_ISS, 8'hC1);
      wr(`OFS_EFE, 8'h00);
      ev_pulse(7'h02);
      rd(`OFS_ISS, 8'hC1);
      wr(`OFS_EFE, 8'h90);
      cts <= 1'b1;
      cyc(3);
      rd(`OFS_ISS, 8'hE0);
      rd(`OFS_MST, 8'h00);
      rd(`OFS_ISS, 8'hC1);
      wr(`OFS_EFE, 8'h50);
      wr(`OFS_IEN, 8'h40);
      rts <= 1'b1;
      cyc(3);
      rd(`OFS_ISS, 8'hE0);
      rd(`OFS_MST, 8'h00);
      rd(`OFS_ISS, 8'hC1);
      done("flow");
      wr(`OFS_TTS, 8'h08);
      wr(`OFS_IEN, 8'h02);
      rd(`OFS_ISS, 8'hC1);
      txe <= 1'b1;
      cyc(3);
      rd(`OFS_ISS, 8'hC2);
      done("rs485");
      apb(1'b0, 12'h040, 32'h0000_0000);
      chk("slverr", 32'h1, {31'h0, qerr});
      chk("prdata", 32'h0, q);
      done("unmapped");
      complete_run();
   end
endmodule : tb_top
